//--- psw_pkg.sv
// Package for the power-save and wake controller: register map, field
// positions, reset values, timing counts and the controller state type.
// Assumes a 50 MHz sys_clk and a plain one-cycle register port.
// Functional notes
// - All peripherals on the divided bus clock change together, same ratio.
// - Idle halts the processor but keeps the core clock source running.
// - Peripherals with stop_in_idle set stop in idle; others keep running.
// - Wait instruction with sleep_select clear enters idle.
// - Enabled interrupt wakes from idle only above processor priority.
// - Any device reset source ends idle.
// - Enabled working source wakes device; low priority leaves it idle, halted.
// - High-priority wake vectors to handler, then resumes after the wait.
// - Idle-wake status flag set leaving idle, sleep-wake flag leaving sleep; here a low-priority drop from sleep to idle sets neither flag.
// - Interrupts with priority zero never wake the device.
// - Oscillator start-up delay precedes resumed execution after an interrupt or watchdog wake from sleep; a reset exit from sleep skips it.
// - Watchdog expiry in low power raises non-maskable interrupt, no reset.
// - Watchdog expiry sets watchdog_timeout_flag in reset_control; here only an expiry that wakes from idle or sleep sets it.
// - Watchdog counter is cleared automatically on every wake.
// - Interrupts during wait entry are deferred until entry completes.
// - Switch command waits start-up and lock of the crystal or PLL source already stored.
// - Two-bit divisor gives 1:1, 1:2, 1:4 or 1:8 bus ratios.
// - Sleep stops the clock source; low-priority interrupt moves to idle.
package psw_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFF_RESET_CTRL = 8'h04;
  localparam logic [7:0] OFF_STOP_IDLE = 8'h08;
  localparam logic [7:0] OFF_STATE = 8'h0C;
  // oscillator_control fields
  localparam int CTRL_SRC_XTAL_BIT = 0;
  localparam int CTRL_SRC_PLL_BIT = 1;
  localparam int CTRL_SLEEP_SEL_BIT = 4;
  localparam int CTRL_SWITCH_BIT = 8;
  localparam int CTRL_DIV_LO = 19;
  localparam int CTRL_DIV_HI = 20;
  // reset_control fields
  localparam int RC_IDLE_BIT = 2;
  localparam int RC_SLEEP_BIT = 3;
  localparam int RC_WATCHDOG_BIT = 4;
  // Reset values
  localparam logic [1:0] DIV_RESET = 2'h0;
  localparam logic SLEEP_SEL_RESET = 1'b0;
  localparam logic [1:0] SRC_RESET = 2'h0;
  // Timing in its own unit, then derived cycle counts (least times round up)
  localparam int CLK_PERIOD_NS = 20;
  localparam int OSC_START_NS = 1000;
  localparam int PLL_LOCK_NS = 2000;
  localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_W = 12;
  // Controller states
  typedef enum logic [2:0] {
    PSW_RUN,
    PSW_ENTER,
    PSW_IDLE,
    PSW_SLEEP,
    PSW_STARTUP,
    PSW_SWITCH
  } psw_state_type;
endpackage : psw_pkg

//--- psw_pb_divider.sv
// Peripheral bus clock divider producing a one-cycle enable pulse.
// Assumes every peripheral on the divided bus uses this single pulse.
`timescale 1ns/100ps
`default_nettype none
module psw_pb_divider
  import psw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [1:0] div_sel,
  output logic pb_tick
);
  logic [2:0] count;
  logic [1:0] active_div;
  logic [2:0] limit;

  // Terminal count for the ratio in force: 1, 2, 4 or 8 cycles per tick
  always_comb begin
    case (active_div)
      2'h0: limit = 3'h0;
      2'h1: limit = 3'h1;
      2'h2: limit = 3'h3;
      default: limit = 3'h7;
    endcase
  end

  // boundary-only reload
  // The ratio is only reloaded at wrap, so no period is ever cut short
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 3'h0;
      active_div <= DIV_RESET;
    end else if (run) begin
      if (count >= limit) begin
        count <= 3'h0;
        active_div <= div_sel;
      end else begin
        count <= count + 3'h1;
      end
    end
  end

  // one shared tick
  // One pulse for all peripherals keeps them in step at one ratio
  assign pb_tick = run && (count >= limit);
endmodule : psw_pb_divider
`default_nettype wire

//--- psw_power_ctrl.sv
// Power-save and wake controller: idle and sleep entry on wait, wake
// decisions on interrupts, resets and watchdog expiry, wake-cause flags,
// oscillator start-up delays and peripheral bus clock gating.
// Assumes the core pulses wait_exec for one cycle when it executes a wait,
// and interrupt inputs are levels held until serviced.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module psw_power_ctrl
  import psw_pkg::*;
#(
  parameter int N_IRQ = 8,
  parameter int N_PERIPH = 8,
  parameter int PRIO_W = 3,
  parameter int OSC_DELAY = OSC_START_CYC,
  parameter int PLL_DELAY = PLL_LOCK_CYC
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic wait_exec,
  input wire logic [PRIO_W-1:0] cpu_priority,
  input wire logic [N_IRQ-1:0] irq_pending,
  input wire logic [N_IRQ-1:0] interrupt_enable_regs,
  input wire logic [N_IRQ*PRIO_W-1:0] irq_priority,
  input wire logic [N_IRQ-1:0] irq_sleep_ok,
  input wire logic device_reset_req,
  input wire logic watchdog_expired,
  output logic cpu_halt,
  output logic cpu_vector,
  output logic [$clog2(N_IRQ)-1:0] cpu_vector_id,
  output logic nmi_reset_vector,
  output logic watchdog_clear,
  output logic osc_enable,
  output logic peripheral_bus_clock,
  output logic [N_PERIPH-1:0] periph_clk_en,
  output logic in_idle,
  output logic in_sleep
);
  localparam int IDW = $clog2(N_IRQ);

  psw_state_type state;
  psw_state_type next_state;

  // Software-visible control
  logic sleep_select;
  logic [1:0] bus_divisor_field;
  logic [1:0] clock_source;
  logic [N_PERIPH-1:0] stop_in_idle;
  // reset_control wake-cause flags
  logic idle_wake_flag;
  logic sleep_wake_flag;
  logic watchdog_timeout_flag;

  // Wake bookkeeping
  logic [DELAY_W-1:0] delay_count;
  logic pend_vector;
  logic pend_nmi;
  logic [IDW-1:0] pend_id;
  logic wake_pulse;

  // Candidate search results
  logic [PRIO_W-1:0] idle_best_prio;
  logic [IDW-1:0] idle_best_id;
  logic [PRIO_W-1:0] sleep_best_prio;
  logic [IDW-1:0] sleep_best_id;
  logic idle_hi;
  logic sleep_hi;
  logic sleep_lo;
  logic startup_needed;
  logic [DELAY_W-1:0] startup_len;
  logic pb_tick;
  logic switch_req;

  // Highest-priority enabled pending source within a mask; returns {id, prio}
  function automatic logic [IDW+PRIO_W-1:0] best_source(
    input logic [N_IRQ-1:0] cand,
    input logic [N_IRQ*PRIO_W-1:0] prios
  );
    logic [PRIO_W-1:0] bp;
    logic [IDW-1:0] bi;
    logic [PRIO_W-1:0] p;
    bp = '0;
    bi = '0;
    for (int i = 0; i < N_IRQ; i++) begin
      p = prios[i*PRIO_W +: PRIO_W];
      if (cand[i] && (p > bp)) begin
        bp = p;
        bi = IDW'(i);
      end
    end
    return {bi, bp};
  endfunction : best_source

  assign {idle_best_id, idle_best_prio} =
    best_source(irq_pending & interrupt_enable_regs, irq_priority);
  assign {sleep_best_id, sleep_best_prio} =
    best_source(irq_pending & interrupt_enable_regs & irq_sleep_ok, irq_priority);

  assign idle_hi = idle_best_prio > cpu_priority;
  assign sleep_hi = sleep_best_prio > cpu_priority;
  // nonzero but not above: drop to idle
  assign sleep_lo = (sleep_best_prio != '0) && !sleep_hi;

  // crystal and PLL sources need start-up and lock time
  always_comb begin
    startup_len = '0;
    if (clock_source[CTRL_SRC_XTAL_BIT]) begin
      startup_len = startup_len + DELAY_W'(OSC_DELAY);
    end
    if (clock_source[CTRL_SRC_PLL_BIT]) begin
      startup_len = startup_len + DELAY_W'(PLL_DELAY);
    end
  end
  assign startup_needed = startup_len != '0;
  assign switch_req = reg_wr && (reg_addr == OFF_OSC_CTRL) && reg_wdata[CTRL_SWITCH_BIT];

  // Next-state decision
  always_comb begin
    next_state = state;
    case (state)
      PSW_RUN: begin
        if (switch_req && startup_needed) begin
          next_state = PSW_SWITCH;
        end else if (wait_exec) begin
          next_state = PSW_ENTER;
        end
      end
      // entry completes before any wake is looked at
      PSW_ENTER: begin
        next_state = sleep_select ? PSW_SLEEP : PSW_IDLE;
      end
      PSW_IDLE: begin
        if (device_reset_req) begin
          next_state = PSW_RUN;
        end else if (watchdog_expired || idle_hi) begin
          next_state = PSW_RUN;
        end
      end
      PSW_SLEEP: begin
        if (device_reset_req) begin
          next_state = PSW_RUN;
        end else if (watchdog_expired || sleep_hi) begin
          // wait for the oscillator before running
          next_state = startup_needed ? PSW_STARTUP : PSW_RUN;
        end else if (sleep_lo) begin
          next_state = PSW_IDLE;
        end
      end
      PSW_STARTUP, PSW_SWITCH: begin
        if (delay_count <= DELAY_W'(1)) begin
          next_state = PSW_RUN;
        end
      end
      default: next_state = PSW_RUN;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= PSW_RUN;
    end else begin
      state <= next_state;
    end
  end

  // start-up delay counter, loaded on entry to a delay state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      delay_count <= '0;
    end else if ((next_state == PSW_STARTUP || next_state == PSW_SWITCH) &&
                 state != next_state) begin
      delay_count <= startup_len;
    end else if (delay_count != '0) begin
      delay_count <= delay_count - DELAY_W'(1);
    end
  end

  // Remember why we woke, so the action fires once the clock is usable
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_vector <= 1'b0;
      pend_nmi <= 1'b0;
      pend_id <= '0;
    end else if (state == PSW_SLEEP && !device_reset_req &&
                 (watchdog_expired || sleep_hi)) begin
      pend_nmi <= watchdog_expired;
      pend_vector <= !watchdog_expired;
      pend_id <= sleep_best_id;
    end else if (state == PSW_IDLE && !device_reset_req &&
                 (watchdog_expired || idle_hi)) begin
      pend_nmi <= watchdog_expired;
      pend_vector <= !watchdog_expired;
      pend_id <= idle_best_id;
    end else if (next_state == PSW_RUN) begin
      pend_nmi <= 1'b0;
      pend_vector <= 1'b0;
    end
  end

  // Wake is any exit from a low-power state back toward execution
  assign wake_pulse = (state == PSW_IDLE || state == PSW_SLEEP) &&
                      (next_state == PSW_RUN || next_state == PSW_STARTUP);

  // Core-facing pulses, registered so they line up with the halt release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_vector <= 1'b0;
      cpu_vector_id <= '0;
      nmi_reset_vector <= 1'b0;
      watchdog_clear <= 1'b0;
    end else begin
      // clear the watchdog on every wake
      watchdog_clear <= wake_pulse;
      cpu_vector <= 1'b0;
      nmi_reset_vector <= 1'b0;
      if (next_state == PSW_RUN && !device_reset_req) begin
        if (state == PSW_IDLE || state == PSW_SLEEP) begin
          // watchdog wins the race as a non-maskable jump
          nmi_reset_vector <= watchdog_expired;
          cpu_vector <= !watchdog_expired;
          cpu_vector_id <= (state == PSW_IDLE) ? idle_best_id : sleep_best_id;
        end else if (state == PSW_STARTUP) begin
          nmi_reset_vector <= pend_nmi;
          cpu_vector <= pend_vector;
          cpu_vector_id <= pend_id;
        end
      end
    end
  end

  // Control register writes; the switch bit is a command, not stored
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_select <= SLEEP_SEL_RESET;
      bus_divisor_field <= DIV_RESET;
      clock_source <= SRC_RESET;
    end else if (reg_wr && reg_addr == OFF_OSC_CTRL) begin
      sleep_select <= reg_wdata[CTRL_SLEEP_SEL_BIT];
      bus_divisor_field <= reg_wdata[CTRL_DIV_HI:CTRL_DIV_LO];
      clock_source <= reg_wdata[CTRL_SRC_PLL_BIT:CTRL_SRC_XTAL_BIT];
    end
  end

  // Per-peripheral stop_in_idle bits
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stop_in_idle <= '0;
    end else if (reg_wr && reg_addr == OFF_STOP_IDLE) begin
      stop_in_idle <= reg_wdata[N_PERIPH-1:0];
    end
  end

  // wake-cause flags; write one to clear, a coincident set wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_wake_flag <= 1'b0;
      sleep_wake_flag <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFF_RESET_CTRL) begin
        if (reg_wdata[RC_IDLE_BIT]) begin
          idle_wake_flag <= 1'b0;
        end
        if (reg_wdata[RC_SLEEP_BIT]) begin
          sleep_wake_flag <= 1'b0;
        end
        if (reg_wdata[RC_WATCHDOG_BIT]) begin
          watchdog_timeout_flag <= 1'b0;
        end
      end
      if (wake_pulse && state == PSW_IDLE) begin
        idle_wake_flag <= 1'b1;
      end
      if (wake_pulse && state == PSW_SLEEP) begin
        sleep_wake_flag <= 1'b1;
      end
      if (wake_pulse && watchdog_expired && !device_reset_req) begin
        watchdog_timeout_flag <= 1'b1;
      end
    end
  end

  // Read port: data stand in the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          OFF_OSC_CTRL: begin
            reg_rdata[CTRL_DIV_HI:CTRL_DIV_LO] <= bus_divisor_field;
            reg_rdata[CTRL_SLEEP_SEL_BIT] <= sleep_select;
            reg_rdata[CTRL_SRC_PLL_BIT:CTRL_SRC_XTAL_BIT] <= clock_source;
          end
          OFF_RESET_CTRL: begin
            reg_rdata[RC_IDLE_BIT] <= idle_wake_flag;
            reg_rdata[RC_SLEEP_BIT] <= sleep_wake_flag;
            reg_rdata[RC_WATCHDOG_BIT] <= watchdog_timeout_flag;
          end
          OFF_STOP_IDLE: reg_rdata[N_PERIPH-1:0] <= stop_in_idle;
          OFF_STATE: reg_rdata[2:0] <= 3'(state);
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // sleep stops the source and the bus clock
  // The bus clock keeps ticking in idle and start-up so peripherals can run
  psw_pb_divider u_divider (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .run(state != PSW_SLEEP),
    .div_sel(bus_divisor_field),
    .pb_tick(pb_tick)
  );
  assign peripheral_bus_clock = pb_tick;

  assign periph_clk_en = (state == PSW_IDLE) ? ({N_PERIPH{pb_tick}} & ~stop_in_idle) :
                         {N_PERIPH{pb_tick}};

  // idle keeps the source on; only sleep turns it off
  assign osc_enable = state != PSW_SLEEP;
  // halt drops on the edge that returns to run
  assign cpu_halt = state != PSW_RUN;
  assign in_idle = state == PSW_IDLE;
  assign in_sleep = state == PSW_SLEEP;
endmodule : psw_power_ctrl
`default_nettype wire

//--- psw_power_ctrl_asserts.sv
// Checker for the power-save controller: entry, wake and clock-gating relations.
// Assumes one sys_clk domain and sees only the controller's own ports.
`timescale 1ns/100ps
`default_nettype none
module psw_chk
  import psw_pkg::*;
#(
  parameter int N_IRQ = 8,
  parameter int N_PERIPH = 8,
  parameter int PRIO_W = 3
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic wait_exec,
  input wire logic [PRIO_W-1:0] cpu_priority,
  input wire logic [N_IRQ-1:0] irq_pending,
  input wire logic [N_IRQ-1:0] interrupt_enable_regs,
  input wire logic [N_IRQ*PRIO_W-1:0] irq_priority,
  input wire logic device_reset_req,
  input wire logic watchdog_expired,
  input wire logic cpu_halt,
  input wire logic cpu_vector,
  input wire logic nmi_reset_vector,
  input wire logic watchdog_clear,
  input wire logic osc_enable,
  input wire logic peripheral_bus_clock,
  input wire logic [N_PERIPH-1:0] periph_clk_en,
  input wire logic in_idle,
  input wire logic in_sleep
);
  logic hi_wake;
  wire logic quiet = !device_reset_req && !watchdog_expired;
  // Enabled source above processor priority; priority zero can never qualify
  always_comb begin
    hi_wake = 1'b0;
    for (int i = 0; i < N_IRQ; i++) begin
      if (irq_pending[i] && interrupt_enable_regs[i]
          && irq_priority[i*PRIO_W +: PRIO_W] > cpu_priority) begin
        hi_wake = 1'b1;
      end
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_enter;
    cpu_halt && !in_idle && !in_sleep ##1 (in_idle || in_sleep);
  endsequence
  sequence s_resume;
    !cpu_halt && watchdog_clear;
  endsequence
  wait_entry_a: assert property (!cpu_halt && wait_exec && !reg_wr && quiet |=> s_enter)
    else $error("wait did not enter low power");
  halt_low_a: assert property ((in_idle || in_sleep) |-> cpu_halt && osc_enable == in_idle)
    else $error("halt or oscillator wrong in low power");
  idle_hold_a: assert property (in_idle && !hi_wake && quiet |=> in_idle)
    else $error("idle left without a qualifying wake");
  idle_wake_a: assert property (in_idle && hi_wake && quiet |=> s_resume ##0 cpu_vector)
    else $error("idle wake did not vector");
  reset_exit_a: assert property ((in_idle || in_sleep) && device_reset_req |=> s_resume ##0 !cpu_vector)
    else $error("reset did not end low power");
  wdt_nmi_a: assert property (in_idle && watchdog_expired && !device_reset_req
                              |=> s_resume ##0 nmi_reset_vector)
    else $error("watchdog expiry gave no nmi");
  start_delay_a: assert property ($fell(in_sleep) && !in_idle && cpu_halt |-> cpu_halt [*2])
    else $error("start-up delay cut short");
  run_enable_a: assert property (!in_idle |-> periph_clk_en == {N_PERIPH{peripheral_bus_clock}})
    else $error("peripheral enables differ from bus tick");
  idle_mask_a: assert property (in_idle |-> (periph_clk_en & ~{N_PERIPH{peripheral_bus_clock}}) == '0)
    else $error("peripheral enabled off a bus tick");
endmodule : psw_chk
bind psw_power_ctrl psw_chk #(.N_IRQ(N_IRQ), .N_PERIPH(N_PERIPH), .PRIO_W(PRIO_W)) u_chk (
  .sys_clk, .reset_n, .reg_wr, .wait_exec, .cpu_priority, .irq_pending, .interrupt_enable_regs,
  .irq_priority, .device_reset_req, .watchdog_expired, .cpu_halt, .cpu_vector, .nmi_reset_vector,
  .watchdog_clear, .osc_enable, .peripheral_bus_clock, .periph_clk_en, .in_idle, .in_sleep);
`default_nettype wire

//--- psw_core_model.sv
// Model of the processor core and interrupt sources beside the controller.
// Assumes the bench asks for waits and raises interrupts by one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module psw_core_model
  import psw_pkg::*;
#(
  parameter int N_IRQ = 8
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic do_wait,
  input wire logic [N_IRQ-1:0] irq_raise,
  input wire logic cpu_vector,
  input wire logic [$clog2(N_IRQ)-1:0] cpu_vector_id,
  input wire logic nmi_reset_vector,
  output logic wait_exec,
  output logic [N_IRQ-1:0] irq_pending,
  output logic [7:0] eret_count
);
  // Wait instruction shows as a single-cycle pulse
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) wait_exec <= 1'b0;
    else wait_exec <= do_wait;
  end
  // Levels stay until the handler is entered, so deferred requests survive
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) irq_pending <= '0;
    else irq_pending <= (irq_pending | irq_raise) & ~(N_IRQ'(cpu_vector) << cpu_vector_id);
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) eret_count <= 8'h00;
    else eret_count <= eret_count + 8'(nmi_reset_vector);
  end
endmodule : psw_core_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the power-save controller and its core model.
// Assumes shortened start-up counts; register reads are checked from a queue.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import psw_pkg::*;
  logic sys_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, do_wait = 0, rd_d = 0;
  logic device_reset_req = 0, watchdog_expired = 0;
  logic [7:0] reg_addr = '0, irq_raise = '0, interrupt_enable_regs = '1, irq_sleep_ok = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic [2:0] cpu_priority = '0, cpu_vector_id, vid;
  logic [23:0] irq_priority = '0;
  logic [7:0] irq_pending, periph_clk_en, eret_count, stop;
  logic cpu_halt, cpu_vector, nmi_reset_vector, watchdog_clear, osc_enable;
  logic peripheral_bus_clock, in_idle, in_sleep, wait_exec;
  int miscompares = 0, checks_done = 0, cyc = 0, nvec = 0, nnmi = 0, gap = 0, since = 1;
  int src, src2, nclr = 0;
  logic [31:0] exp_q[$];
  psw_power_ctrl #(.OSC_DELAY(2), .PLL_DELAY(3)) dut (.sys_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .wait_exec, .cpu_priority, .irq_pending, .interrupt_enable_regs,
    .irq_priority, .irq_sleep_ok, .device_reset_req, .watchdog_expired, .cpu_halt, .cpu_vector,
    .cpu_vector_id, .nmi_reset_vector, .watchdog_clear, .osc_enable, .peripheral_bus_clock,
    .periph_clk_en, .in_idle, .in_sleep);
  psw_core_model u_core (.sys_clk, .reset_n, .do_wait, .irq_raise, .cpu_vector, .cpu_vector_id,
    .nmi_reset_vector, .wait_exec, .irq_pending, .eret_count);
  always #10 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // One idle edge, so a following call never re-raises the strobe in this step
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(want);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask : rd
  task automatic go_low;
    do_wait <= 1'b1;
    @(posedge sys_clk);
    do_wait <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : go_low
  task automatic raise(input int i, input logic [2:0] p);
    irq_priority[i*3 +: 3] <= p;
    irq_raise <= 8'h01 << i;
    @(posedge sys_clk);
    irq_raise <= '0;
    for (int k = 0; k < 20 && cpu_halt === 1'b1 && !in_idle; k++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask : raise
  // Read data, events, tick spacing and the hang limit, all seen at the edge
  always @(posedge sys_clk) begin
    if (rd_d) check(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
    if (cpu_vector === 1'b1) begin
      nvec++;
      vid = cpu_vector_id;
    end
    if (nmi_reset_vector === 1'b1) nnmi++;
    if (watchdog_clear === 1'b1) nclr++;
    if (peripheral_bus_clock === 1'b1) begin
      gap = since;
      since = 1;
    end else since++;
    cyc++;
    if (cyc > 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(60));
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h0c, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    $display("test reset_values done");
    for (int d = 3; d >= 0; d--) begin
      wr(8'h00, 32'(d) << 19);
      repeat (20) @(posedge sys_clk);
      check(32'(gap), 32'(1) << d);
      rd(8'h00, 32'(d) << 19);
    end
    $display("test bus_divisor done");
    stop = 8'($urandom());
    src = $urandom_range(7);
    src2 = (src + 1) % 8;
    cpu_priority <= 3'h2;
    wr(8'h08, 32'(stop));
    go_low();
    @(negedge sys_clk);
    check(32'(in_idle), 32'h0000_0001);
    check(32'(periph_clk_en), {24'h00_0000, ~stop});
    @(posedge sys_clk);
    raise(src, 3'h0);
    check(32'(in_idle), 32'h0000_0001);
    raise(src, 3'h2);
    check(32'(in_idle), 32'h0000_0001);
    interrupt_enable_regs[src] <= 1'b0;
    raise(src, 3'h3);
    check(32'(in_idle), 32'h0000_0001);
    interrupt_enable_regs <= '1;
    raise(src, 3'h3);
    check(32'(cpu_halt), 32'h0000_0000);
    check(32'(vid), 32'(src));
    rd(8'h04, 32'h0000_0004);
    wr(8'h04, 32'h0000_0004);
    rd(8'h04, 32'h0000_0000);
    $display("test idle_wake done");
    wr(8'h00, 32'h0000_0011);
    go_low();
    check(32'(in_sleep), 32'h0000_0001);
    check(32'(osc_enable), 32'h0000_0000);
    raise(src2, 3'h5);
    check(32'(in_sleep), 32'h0000_0001);
    irq_sleep_ok <= 8'hff;
    for (int k = 0; k < 20 && cpu_halt === 1'b1; k++) @(posedge sys_clk);
    // The loop may see the halt drop in the launching step; let the monitor count first
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(32'(nvec), 32'h0000_0002);
    check(32'(vid), 32'(src2));
    @(posedge sys_clk);
    rd(8'h04, 32'h0000_0008);
    wr(8'h04, 32'h0000_0008);
    go_low();
    raise(src, 3'h1);
    check(32'(in_idle), 32'h0000_0001);
    $display("test sleep_wake done");
    watchdog_expired <= 1'b1;
    @(posedge sys_clk);
    watchdog_expired <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(32'(nnmi), 32'h0000_0001);
    check(32'(eret_count), 32'h0000_0001);
    rd(8'h04, 32'h0000_0014);
    wr(8'h04, 32'h0000_001c);
    // Switch with the crystal source still stored: halted for the start-up count
    wr(8'h00, 32'h0000_0103);
    check(32'(cpu_halt), 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    check(32'(cpu_halt), 32'h0000_0000);
    wr(8'h00, 32'h0000_0000);
    go_low();
    device_reset_req <= 1'b1;
    @(posedge sys_clk);
    device_reset_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(32'(cpu_halt), 32'h0000_0000);
    check(32'(nvec), 32'h0000_0002);
    rd(8'h04, 32'h0000_0004);
    repeat (3) @(posedge sys_clk);
    check(32'(nclr), 32'h0000_0004);
    $display("test nmi_and_reset done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
